// File: rtl/adc_cfg_pkg.sv
/*
  Constants and carrier types for the converter's mode-selection and
  configuration block. Assumes a single 100 MHz system clock domain.
*/
package adc_cfg_pkg;

  localparam int FRAME_BITS = 24;
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 16;

  localparam logic [3:0] ADDR_MAIN = 4'h0;
  localparam logic [3:0] ADDR_OFFSET_I = 4'h2;
  localparam logic [3:0] ADDR_RANGE_I = 4'h3;
  localparam logic [3:0] ADDR_CAL_ADJ = 4'h4;
  localparam logic [3:0] ADDR_SKEW = 4'h7;
  localparam logic [3:0] ADDR_OFFSET_Q = 4'hA;
  localparam logic [3:0] ADDR_RANGE_Q = 4'hB;
  localparam logic [3:0] ADDR_PHASE_C = 4'hC;
  localparam logic [3:0] ADDR_PHASE_F = 4'hD;
  localparam logic [3:0] ADDR_SYNC = 4'hE;
  localparam logic [15:0] MAPPED_MASK = 16'h7C9D;

  localparam int BIT_CAL = 15;
  localparam int BIT_PHASE = 14;
  localparam int BIT_SWING = 13;
  localparam int BIT_TEST = 12;
  localparam int BIT_PD_I = 11;
  localparam int BIT_PD_Q = 10;
  localparam int BIT_INTERLEAVE = 7;
  localparam int BIT_TWOS = 4;
  localparam int BIT_TSTAMP = 3;
  localparam int BIT_CAL_ACCESS = 7;
  localparam int BIT_OUTPUT_DATA_CLOCK_RESET = 0;
  localparam int RANGE_W = 15;

  localparam logic [15:0] MAIN_RESET = 16'h2000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] RANGE_RESET = 16'h4000;
  localparam logic [15:0] CAL_ADJ_RESET = 16'h0000;
  localparam logic [15:0] SKEW_RESET = 16'h0040;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [15:0] SYNC_RESET = 16'h0000;
  localparam logic [RANGE_W-1:0] RANGE_MID = 15'h4000;
  localparam logic [RANGE_W-1:0] RANGE_MIN = 15'h0000;

  localparam logic [15:0][15:0] REG_RESET = '{
    16'h0000, SYNC_RESET, PHASE_RESET, PHASE_RESET, RANGE_RESET, OFFSET_RESET,
    16'h0000, 16'h0000, SKEW_RESET, 16'h0000, 16'h0000, CAL_ADJ_RESET,
    RANGE_RESET, OFFSET_RESET, 16'h0000, MAIN_RESET};

  typedef struct packed {
    logic scs_n;
    logic sclk;
    logic sdi;
    logic mode_sel;
    logic interleave;
    logic range;
    logic phase;
    logic test;
    logic cal;
    logic cal_delay;
    logic pd_i;
    logic pd_q;
    logic coupling;
    logic common_mode;
    logic demux;
  } pins_t;

  typedef struct packed {
    logic extended_control_mode;
    logic interleave;
    logic output_phase_select;
    logic output_swing_select;
    logic twos_complement_select;
    logic test_pattern_select;
    logic time_stamp_enable;
    logic output_data_clock_reset_enable;
    logic cal_request;
    logic cal_value_access_enable;
    logic power_down_i;
    logic power_down_q;
    logic power_on_cal_delay;
    logic coupling_mode;
    logic output_common_mode;
    logic demux_mode;
    logic [RANGE_W-1:0] range_i;
    logic [RANGE_W-1:0] range_q;
    logic [15:0] offset_i;
    logic [15:0] offset_q;
    logic [15:0] skew;
    logic [15:0] phase_coarse;
    logic [15:0] phase_fine;
    logic [15:0] sync_ctrl;
    logic [15:0] cal_adjust;
  } eff_t;

endpackage

// File: rtl/adc_mode_select_config.sv
/*
  Mode selection and configuration registers of a dual-channel converter,
  with the 24-bit serial register port. Assumes all pins are asynchronous
  to clk_sys and that the serial clock is far slower than clk_sys.
*/
module adc_mode_select_config
  import adc_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire pins_t pins,
  output logic sdo,
  output logic sdo_oe,
  output eff_t eff
);

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic sclk_d;
    logic [4:0] rise_cnt;
    logic [22:0] shift_in;
    logic rw;
    logic [3:0] addr;
    logic [15:0] shift_out;
    logic [4:0] sent;
    logic sdo;
    logic sdo_oe;
    logic cal_pulse;
    logic [15:0][15:0] regs;
    eff_t eff;
  } state_t;

  localparam state_t ST_RESET = '{
    s1: '1, s2: '1, sclk_d: 1'b1, rise_cnt: '0, shift_in: '0, rw: 1'b0,
    addr: '0, shift_out: '0, sent: '0, sdo: 1'b0, sdo_oe: 1'b0,
    cal_pulse: 1'b0, regs: REG_RESET, eff: '0};

  state_t st_r;
  state_t st_nxt;

  always_comb begin
    logic rise;
    logic fall;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ext;
    st_nxt = st_r;
    rise = 1'b0;
    fall = 1'b0;
    wdata = '0;
    rdata = '0;
    ext = 1'b0;
    // Second stage reads only the first stage
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.sclk_d = st_r.s2.sclk;
    rise = st_r.s2.sclk && !st_r.sclk_d;
    fall = !st_r.s2.sclk && st_r.sclk_d;
    ext = !st_r.s2.mode_sel;
    st_nxt.cal_pulse = 1'b0;

    if (st_r.s2.scs_n) begin
      // Frame ended or never began: abort and release the data line
      st_nxt.rise_cnt = '0;
      st_nxt.sent = '0;
      st_nxt.sdo_oe = 1'b0;
      st_nxt.sdo = 1'b0;
    end else begin
      if (rise && st_r.rise_cnt != 5'(FRAME_BITS)) begin
        st_nxt.rise_cnt = st_r.rise_cnt + 5'd1;
        st_nxt.shift_in = {st_r.shift_in[21:0], st_r.s2.sdi};
        if (st_r.rise_cnt == 5'(CMD_BITS - 1)) begin
          // Command complete: read bit first, address in bits four to seven
          st_nxt.rw = st_r.shift_in[6];
          st_nxt.addr = st_r.shift_in[3:0];
          // Unmapped addresses read as zero
          rdata = MAPPED_MASK[st_r.shift_in[3:0]] ? st_r.regs[st_r.shift_in[3:0]] : '0;
          st_nxt.shift_out = rdata;
        end
        if (st_r.rise_cnt == 5'(FRAME_BITS - 1) && !st_r.rw && ext) begin
          // Write lands only on the 24th edge; short frames write nothing
          wdata = {st_r.shift_in[14:0], st_r.s2.sdi};
          if (MAPPED_MASK[st_r.addr]) begin
            st_nxt.regs[st_r.addr] = wdata;
          end
          if (st_r.addr == ADDR_MAIN) begin
            // Calibration bit never stores; it only fires a command
            st_nxt.regs[ADDR_MAIN][BIT_CAL] = 1'b0;
            st_nxt.cal_pulse = wdata[BIT_CAL];
          end
        end
      end
      if (fall && st_r.rw && st_r.rise_cnt >= 5'(CMD_BITS)) begin
        st_nxt.sdo_oe = 1'b1;
        // After the last data bit the line holds the final bit
        if (st_r.sent != 5'(DATA_BITS)) begin
          st_nxt.sdo = st_r.shift_out[15];
          st_nxt.shift_out = {st_r.shift_out[14:0], 1'b0};
          st_nxt.sent = st_r.sent + 5'd1;
        end
      end
    end

    if (!ext) begin
      // Leaving extended mode restores every default and holds it
      st_nxt.regs = REG_RESET;
    end

    // Every effective setting is registered, so a mode change cannot glitch
    st_nxt.eff.extended_control_mode = ext;
    st_nxt.eff.interleave = ext ? st_r.regs[ADDR_MAIN][BIT_INTERLEAVE]
                                : st_r.s2.interleave;
    st_nxt.eff.output_phase_select = ext ? st_r.regs[ADDR_MAIN][BIT_PHASE]
                                         : st_r.s2.phase;
    st_nxt.eff.output_swing_select = ext ? st_r.regs[ADDR_MAIN][BIT_SWING]
                                         : 1'b1;
    st_nxt.eff.twos_complement_select = ext && st_r.regs[ADDR_MAIN][BIT_TWOS];
    st_nxt.eff.test_pattern_select = ext ? st_r.regs[ADDR_MAIN][BIT_TEST]
                                         : st_r.s2.test;
    st_nxt.eff.time_stamp_enable = ext && st_r.regs[ADDR_MAIN][BIT_TSTAMP];
    st_nxt.eff.output_data_clock_reset_enable = ext && st_r.regs[ADDR_SYNC][BIT_OUTPUT_DATA_CLOCK_RESET];
    st_nxt.eff.cal_request = st_r.s2.cal || st_r.cal_pulse;
    st_nxt.eff.cal_value_access_enable = ext && st_r.regs[ADDR_CAL_ADJ][BIT_CAL_ACCESS];
    st_nxt.eff.power_down_i = st_r.s2.pd_i || (ext && st_r.regs[ADDR_MAIN][BIT_PD_I]);
    st_nxt.eff.power_down_q = st_r.s2.pd_q || (ext && st_r.regs[ADDR_MAIN][BIT_PD_Q]);
    st_nxt.eff.power_on_cal_delay = st_r.s2.cal_delay;
    st_nxt.eff.coupling_mode = st_r.s2.coupling;
    st_nxt.eff.output_common_mode = st_r.s2.common_mode;
    st_nxt.eff.demux_mode = st_r.s2.demux;
    // Pin levels map onto the register middle and minimum codes
    st_nxt.eff.range_i = ext ? st_r.regs[ADDR_RANGE_I][RANGE_W-1:0]
                             : (st_r.s2.range ? RANGE_MID : RANGE_MIN);
    st_nxt.eff.range_q = ext ? st_r.regs[ADDR_RANGE_Q][RANGE_W-1:0]
                             : (st_r.s2.range ? RANGE_MID : RANGE_MIN);
    // Outside extended mode these registers already sit at their defaults
    st_nxt.eff.offset_i = st_r.regs[ADDR_OFFSET_I];
    st_nxt.eff.offset_q = st_r.regs[ADDR_OFFSET_Q];
    st_nxt.eff.skew = st_r.regs[ADDR_SKEW];
    st_nxt.eff.phase_coarse = st_r.regs[ADDR_PHASE_C];
    st_nxt.eff.phase_fine = st_r.regs[ADDR_PHASE_F];
    st_nxt.eff.sync_ctrl = st_r.regs[ADDR_SYNC];
    st_nxt.eff.cal_adjust = st_r.regs[ADDR_CAL_ADJ];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sdo = st_r.sdo;
  assign sdo_oe = st_r.sdo_oe;
  assign eff = st_r.eff;

endmodule

// File: bench/adc_cfg_chk.sv
/* Port checker for the mode-select and configuration block.
   Bound to the top module; sees its ports only, one clock domain. */
module adc_cfg_chk
  import adc_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire pins_t pins,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire eff_t eff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Five samples span two sync stages plus the output register
  a_mode_follows_pin: assert property (
    $stable(pins.mode_sel)[*5] |-> eff.extended_control_mode == !pins.mode_sel)
    else $error("mode flag does not follow pin");
  a_pin_mode_defaults: assert property (pins.mode_sel[*6] |->
    eff.output_swing_select && !eff.twos_complement_select && eff.skew == SKEW_RESET)
    else $error("pin mode settings not at default");
  a_range_pin_map: assert property (
    (pins.mode_sel && $stable(pins.range))[*6] |-> eff.range_q == eff.range_i &&
    eff.range_i == (pins.range ? RANGE_MID : RANGE_MIN)) else $error("range pin map wrong");
  a_pin_selects: assert property (
    (pins.mode_sel && $stable({pins.interleave, pins.phase, pins.test}))[*6] |->
    {eff.interleave, eff.output_phase_select, eff.test_pattern_select} ==
    {pins.interleave, pins.phase, pins.test}) else $error("pin mode select wrong");
  a_pd_force: assert property ((pins.pd_i && pins.pd_q)[*5] |->
    eff.power_down_i && eff.power_down_q) else $error("power-down pin ignored");
  a_pin_only_pass: assert property (
    $stable({pins.coupling, pins.common_mode, pins.demux, pins.cal_delay})[*5] |->
    {eff.coupling_mode, eff.output_common_mode, eff.demux_mode, eff.power_on_cal_delay}
    == {pins.coupling, pins.common_mode, pins.demux, pins.cal_delay})
    else $error("pin-only feature wrong");
  a_cal_pin: assert property (pins.cal[*5] |-> eff.cal_request)
    else $error("calibration pin ignored");
  a_sdo_idle: assert property (pins.scs_n[*5] |-> !sdo_oe)
    else $error("serial output driven outside frame");
  c_ext_twos: cover property (eff.extended_control_mode && eff.twos_complement_select);
  c_read_out: cover property (sdo_oe && sdo);
  c_cal_req: cover property (eff.cal_request);
endmodule

// File: bench/cfg_host_model.sv
/* Host controller model for the 24-bit serial register port.
   Assumes a 100 MHz clk_sys; serial clock period is 8 of its cycles. */
module cfg_host_model (
  input wire logic clk_sys,
  input wire logic sdo,
  output logic scs_n,
  output logic sclk,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock rests low between frames; data rests at its pull-up level
  initial begin
    scs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  // Fewer than 24 bits gives a cut-short frame
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [15:0] d,
      input int nbits, output logic [15:0] q);
    logic [23:0] f;
    f = {rd, 2'b10, a, 1'b0, d};
    q = 16'h0000;
    scs_n = 1'b0;
    for (int i = 23; i >= 24 - nbits; i--) begin
      sdi = f[i];
      half();
      sclk = 1'b1;
      half();
      if (i < 16) q[i] = sdo;
      sclk = 1'b0;
    end
    half();
    scs_n = 1'b1;
    sdi = 1'b1;
    half();
  endtask
endmodule

// File: bench/adc_mode_select_config_tb_top.sv
/* Self-checking bench: reset defaults, random register traffic, cut frames,
   pin mode and pin overrides. Assumes the host model drives the serial pins. */
module adc_mode_select_config_tb_top
  import adc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  pins_t fp = '0;
  pins_t pins;
  eff_t eff;
  logic sdo, sdo_oe, scs_n, sclk, sdi;
  logic [15:0] q, d;
  logic [3:0] a;
  int n_errors = 0;
  int compares = 0;
  int n_cal = 0;
  int c;
  always #5 clk_sys = ~clk_sys;
  always_comb begin
    pins = fp;
    {pins.scs_n, pins.sclk, pins.sdi} = {scs_n, sclk, sdi};
  end
  always @(posedge clk_sys) if (eff.cal_request === 1'b1) n_cal++;
  cfg_host_model host (.clk_sys(clk_sys), .sdo(sdo), .scs_n(scs_n), .sclk(sclk), .sdi(sdi));
  adc_mode_select_config uut (.clk_sys(clk_sys), .rst(rst), .pins(pins), .sdo(sdo),
    .sdo_oe(sdo_oe), .eff(eff));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xf(input logic r, input logic [3:0] ad, input logic [15:0] dv);
    host.xfer(r, ad, dv, 24, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic [15:0] fld(input logic [3:0] ad);
    case (ad)
      4'h0: fld = {8'h00, eff.output_phase_select, eff.output_swing_select,
        eff.test_pattern_select, eff.power_down_i, eff.power_down_q, eff.interleave,
        eff.twos_complement_select, eff.time_stamp_enable};
      4'h2: fld = eff.offset_i;
      4'h3: fld = {1'b0, eff.range_i};
      4'h4: fld = {eff.cal_adjust[15:8], eff.cal_value_access_enable, eff.cal_adjust[6:0]};
      4'h7: fld = eff.skew;
      4'hA: fld = eff.offset_q;
      4'hB: fld = {1'b0, eff.range_q};
      4'hC: fld = eff.phase_coarse;
      4'hD: fld = eff.phase_fine;
      default: fld = {eff.sync_ctrl[15:1], eff.output_data_clock_reset_enable};
    endcase
  endfunction
  function automatic logic [15:0] exp_fld(input logic [3:0] ad, input logic [15:0] dv);
    if (ad == 4'h0) return {8'h00, dv[14:10], dv[7], dv[4], dv[3]};
    if (ad == 4'h3 || ad == 4'hB) return {1'b0, dv[14:0]};
    return dv;
  endfunction
  function automatic logic [15:0] exp_rd(input logic [3:0] ad, input logic [15:0] dv);
    return MAPPED_MASK[ad] ? (ad == 4'h0 ? {1'b0, dv[14:0]} : dv) : 16'h0000;
  endfunction
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(24));
    cyc(10);
    rst = 1'b0;
    cyc(4);
    for (int i = 0; i < 16; i++) begin
      xf(1'b1, 4'(i), 16'h0000);
      chk("reset read", REG_RESET[i], q);
      if (MAPPED_MASK[i]) chk("reset field", exp_fld(4'(i), REG_RESET[i]), fld(4'(i)));
    end
    $display("test reset_defaults done");
    host.xfer(1'b0, 4'h7, 16'h1234, 12, q);
    xf(1'b1, 4'h7, 16'h0000);
    chk("cut frame", SKEW_RESET, q);
    $display("test cut_frame done");
    for (int n = 0; n < 40; n++) begin
      a = 4'($urandom_range(15));
      d = 16'($urandom);
      {fp.interleave, fp.phase, fp.test, fp.range} = 4'($urandom);
      {fp.coupling, fp.common_mode, fp.demux, fp.cal_delay} = 4'($urandom);
      c = n_cal;
      xf(1'b0, a, d);
      xf(1'b1, a, 16'h0000);
      chk("readback", exp_rd(a, d), q);
      if (MAPPED_MASK[a]) chk("field", exp_fld(a, d), fld(a));
      chk("cal pulses", 16'(a == 4'h0 && d[15]), 16'(n_cal - c));
      if (a == 4'h3 || a == 4'hB) begin
        fp.cal = 1'b1;
        cyc(8);
        fp.cal = 1'b0;
        // Let the synced pin drain so the next pulse count starts clean
        cyc(4);
      end
    end
    $display("test random_regs done");
    {fp.pd_i, fp.pd_q} = 2'b11;
    cyc(6);
    chk("pd pins", 16'h0003, {14'h0, eff.power_down_i, eff.power_down_q});
    {fp.pd_i, fp.pd_q} = 2'b00;
    // Non-default value so that the pin-mode restore is visible
    xf(1'b0, 4'h7, 16'h0055);
    fp.mode_sel = 1'b1;
    cyc(8);
    xf(1'b0, 4'h7, 16'h0055);
    for (int r = 0; r < 2; r++) begin
      {fp.interleave, fp.phase, fp.test} = 3'($urandom);
      fp.range = r[0];
      cyc(8);
      chk("range pin", 16'(r[0] ? RANGE_MID : RANGE_MIN), 16'(eff.range_i));
      chk("pin sel", {13'h0, fp.interleave, fp.phase, fp.test}, {13'h0, eff.interleave,
        eff.output_phase_select, eff.test_pattern_select});
    end
    fp.mode_sel = 1'b0;
    cyc(8);
    xf(1'b1, 4'h7, 16'h0000);
    chk("pin mode drop", SKEW_RESET, q);
    $display("test pin_mode done");
    end_of_test();
  end
endmodule
bind adc_mode_select_config adc_cfg_chk chk (.clk_sys(clk_sys), .rst(rst), .pins(pins),
  .sdo(sdo), .sdo_oe(sdo_oe), .eff(eff));
